// *** core/seas_pkg.sv ***
// Purpose: shared constants and types of the serial memory slave
// Assumes: 50 MHz core clock, bus pins sampled as plain inputs
// Notes: identifiers and timing counts are named once here
package seas_pkg;

  localparam int           CLK_MHZ      = 50;
  localparam int           T_WR_US      = 5000;
  // longest wait rounds down, never below one cycle
  localparam int           WR_CYCLES    = (T_WR_US * CLK_MHZ < 1) ? 1 : T_WR_US * CLK_MHZ;
  localparam logic [6:0]   ARRAY_ID     = 7'h57;
  localparam logic [6:0]   CTRL_ID      = 7'h6F;
  localparam logic [15:0]  ADDR_RST     = 16'h0000;
  localparam int           ARRAY_AW     = 15;
  localparam int           CTRL_AW      = 6;
  localparam int           ARRAY_PG_AW  = 7;
  localparam int           CTRL_PG_AW   = 3;
  localparam int           FIFO_DEPTH   = 32;
  localparam int           FIFO_W       = 25;
  localparam logic [3:0]   BIT_LAST     = 4'h7;
  localparam logic [3:0]   BIT_ACK      = 4'h8;
  // start's own scl fall wraps this to bit zero
  localparam logic [3:0]   BIT_LEAD     = 4'hF;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_DEV  = 8'h02,
    ST_AHI  = 8'h04,
    ST_ALO  = 8'h08,
    ST_WDAT = 8'h10,
    ST_RDAT = 8'h20,
    ST_BUSY = 8'h40,
    ST_SPR  = 8'h80
  } seas_state_t;

endpackage : seas_pkg

// *** core/seas_fifo.sv ***
// Purpose: write-data buffer between byte load and memory commit
// Assumes: single clock, synchronous flush
// Notes: one slot is never wasted; count tells full from empty
`timescale 1ns/1ns
`default_nettype none
module seas_fifo #(
  parameter int W     = 25,
  parameter int DEPTH = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         flush,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } seas_fifo_t;

  seas_fifo_t   r;
  seas_fifo_t   n;
  logic [W-1:0] mem [DEPTH];
  logic         wr;
  logic         rd;

  assign in_ready  = (r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (r.cnt != '0);
  assign out_data  = mem[r.rp];
  assign wr        = in_valid & in_ready & ~flush;
  assign rd        = out_valid & out_ready & ~flush;

  always_comb begin
    n = r;
    if (flush) begin
      n = '0;
    end else begin
      if (wr) n.wp = (r.wp == AW'(DEPTH-1)) ? '0 : r.wp + 1'b1;
      if (rd) n.rp = (r.rp == AW'(DEPTH-1)) ? '0 : r.rp + 1'b1;
      n.cnt = r.cnt + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) r <= '0;
    else        r <= n;
  end

  always_ff @(posedge clk) begin
    if (wr) mem[r.wp] <= in_data;
  end

endmodule : seas_fifo
`default_nettype wire

// *** core/seas_slave.sv ***
// Purpose: two-wire serial slave reaching a byte array and a control space
// Assumes: scl and sda come from pins; sda is open drain, driven low only
// Notes: link runs far slower than core_clk, so edges are found by sampling
`timescale 1ns/1ns
`default_nettype none
module seas_slave
  import seas_pkg::*;
#(
  parameter int WR_CYC  = WR_CYCLES,
  parameter int AAW     = ARRAY_AW,
  parameter int CAW     = CTRL_AW,
  parameter int FDEPTH  = FIFO_DEPTH
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  output logic      busy
);
  localparam int TW = $clog2(WR_CYC + 1);

  typedef struct packed {
    seas_state_t st;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic [7:0]  tx;
    logic [7:0]  hi;
    logic [15:0] addr;
    logic        space;
    logic        rw;
    logic        hit;
    logic        got;
    logic        mack;
    logic        oe;
    logic        scl_m;
    logic        scl_s;
    logic        scl_d;
    logic        sda_m;
    logic        sda_s;
    logic        sda_d;
    logic [TW-1:0] tmr;
  } seas_regs_t;

  seas_regs_t        r;
  seas_regs_t        n;
  logic [7:0]        arr  [2**AAW];
  logic [7:0]        ctrl [2**CAW];
  logic              rise;
  logic              fall;
  logic              start;
  logic              stop;
  logic              id_ok;
  logic              id_ctrl;
  logic [7:0]        rd_byte;
  logic [15:0]       rd_next;
  logic              push;
  logic              drain;
  logic              flush;
  logic              ld;
  logic              f_in_ready;
  logic              f_out_valid;
  logic [FIFO_W-1:0] f_out;

  // read counter: crosses pages, wraps only at the end of the space
  function automatic logic [15:0] next_rd(input logic sp, input logic [15:0] a);
    logic [15:0] m;
    m = sp ? 16'((2**CAW) - 1) : 16'((2**AAW) - 1);
    next_rd = (a + 16'h0001) & m;
  endfunction : next_rd

  // write counter rolls over inside its page
  function automatic logic [15:0] next_wr(input logic sp, input logic [15:0] a);
    logic [15:0] m;
    m = sp ? 16'((2**CTRL_PG_AW) - 1) : 16'((2**ARRAY_PG_AW) - 1);
    next_wr = (a & ~m) | ((a + 16'h0001) & m);
  endfunction : next_wr

  assign rise    = r.scl_s & ~r.scl_d;
  assign fall    = ~r.scl_s & r.scl_d;
  assign start   = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;
  assign stop    = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;
  assign id_ctrl = (r.sh[7:1] == CTRL_ID);
  assign id_ok   = (r.sh[7:1] == ARRAY_ID) | id_ctrl;
  assign rd_byte = r.space ? ctrl[r.addr[CAW-1:0]] : arr[r.addr[AAW-1:0]];
  assign rd_next = next_rd(r.space, r.addr);
  assign sda_out = 1'b0;
  assign sda_oe  = r.oe;
  assign busy    = (r.st == ST_BUSY);
  assign drain   = busy;

  always_comb begin
    n       = r;
    push    = 1'b0;
    flush   = 1'b0;
    ld      = 1'b0;
    n.scl_m = scl_in;
    n.scl_s = r.scl_m;
    n.scl_d = r.scl_s;
    n.sda_m = sda_in;
    n.sda_s = r.sda_m;
    n.sda_d = r.sda_s;
    if (r.st == ST_BUSY) begin
      // inputs ignored and sda released for the whole commit
      n.oe = 1'b0;
      if (r.tmr == TW'(WR_CYC - 1)) begin
        n.st  = ST_IDLE;
        n.tmr = '0;
      end else begin
        n.tmr = r.tmr + 1'b1;
      end
    end else if (start) begin
      // a start mid write without a stop also drops the load
      flush = 1'b1;
      n.st  = ST_DEV;
      // the scl fall that closes the start is not a bit; it wraps the count to zero
      n.cnt = BIT_LEAD;
      n.oe  = 1'b0;
      n.got = 1'b0;
    end else if (stop) begin
      n.oe  = 1'b0;
      n.st  = ST_IDLE;
      n.cnt = '0;
      if (r.st == ST_WDAT && r.cnt == '0 && r.got) begin
        n.st  = ST_BUSY;
        n.tmr = '0;
      end else begin
        flush = 1'b1;
      end
    end else if (r.st != ST_IDLE) begin
      if (rise && r.cnt < BIT_ACK) begin
        n.sh = {r.sh[6:0], r.sda_s};
      end
      if (rise && r.cnt == BIT_ACK) begin
        n.mack = ~r.sda_s;
      end
      if (fall) begin
        if (r.cnt == BIT_LAST) begin
          n.cnt = BIT_ACK;
          unique case (r.st)
            ST_DEV: begin
              n.hit   = id_ok;
              n.oe    = id_ok;
              n.space = id_ctrl;
              n.rw    = r.sh[0];
            end
            ST_AHI: begin
              n.hi = r.sh;
              n.oe = 1'b1;
            end
            ST_ALO: begin
              n.addr = {r.hi, r.sh};
              n.oe   = 1'b1;
            end
            ST_WDAT: begin
              // full buffer refuses the byte so the master sees a nack
              push  = f_in_ready;
              n.hit = f_in_ready;
              n.oe  = f_in_ready;
            end
            ST_RDAT: begin
              n.oe = 1'b0;
            end
            default: begin
              n.st = ST_IDLE;
            end
          endcase
        end else if (r.cnt == BIT_ACK) begin
          n.cnt = '0;
          n.oe  = 1'b0;
          unique case (r.st)
            ST_DEV: begin
              if (!r.hit) begin
                n.st = ST_IDLE;
              end else if (r.rw) begin
                ld   = 1'b1;
                n.st = ST_RDAT;
              end else begin
                n.st = ST_AHI;
              end
            end
            ST_AHI: begin
              n.st = ST_ALO;
            end
            ST_ALO: begin
              n.st  = ST_WDAT;
              n.got = 1'b0;
            end
            ST_WDAT: begin
              if (r.hit) begin
                n.got  = 1'b1;
                n.addr = next_wr(r.space, r.addr);
              end
            end
            ST_RDAT: begin
              if (r.mack) ld = 1'b1;
              else n.st = ST_IDLE;
            end
            default: begin
              n.st = ST_IDLE;
            end
          endcase
        end else begin
          n.cnt = r.cnt + 4'h1;
          if (r.st == ST_RDAT) begin
            n.tx = {r.tx[6:0], 1'b0};
            n.oe = ~r.tx[6];
          end
        end
      end
      if (ld) begin
        n.tx   = rd_byte;
        n.oe   = ~rd_byte[7];
        n.addr = rd_next;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      r       <= '0;
      r.st    <= ST_IDLE;
      r.addr  <= ADDR_RST;
      r.scl_m <= 1'b1;
      r.scl_s <= 1'b1;
      r.scl_d <= 1'b1;
      r.sda_m <= 1'b1;
      r.sda_s <= 1'b1;
      r.sda_d <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // buffered bytes reach memory only during the commit cycle
  always_ff @(posedge core_clk) begin
    if (drain && f_out_valid) begin
      if (f_out[24]) ctrl[f_out[CAW+7:8]] <= f_out[7:0];
      else           arr[f_out[AAW+7:8]]  <= f_out[7:0];
    end
  end

  seas_fifo #(
    .W     (FIFO_W),
    .DEPTH (FDEPTH)
  ) u_fifo (
    .clk       (core_clk),
    .rst_n     (nrst),
    .flush     (flush),
    .in_valid  (push),
    .in_ready  (f_in_ready),
    .in_data   ({r.space, r.addr, r.sh}),
    .out_valid (f_out_valid),
    .out_ready (drain),
    .out_data  (f_out)
  );

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  abort_flush_a: assert property (
    (stop && r.st == ST_WDAT && r.cnt != '0) |=> (r.st == ST_IDLE && !f_out_valid))
    else $error("aborted write left data queued");

  commit_start_a: assert property (
    (stop && r.st == ST_WDAT && r.cnt == '0 && r.got) |=> busy ##1 busy)
    else $error("valid write stop did not start commit");

  busy_quiet_a: assert property (
    busy |-> !sda_oe)
    else $error("sda driven during commit");

  busy_len_a: assert property (
    busy |-> r.tmr < TW'(WR_CYC))
    else $error("commit timer overran");

  rd_step_a: assert property (
    ld |=> r.addr == $past(rd_next))
    else $error("read counter did not step");

  id_ack_a: assert property (
    (fall && r.cnt == BIT_LAST && r.st == ST_DEV && !start && !stop)
      |=> (sda_oe == $past(id_ok)))
    else $error("address acknowledge does not match identifier");

  tx_bit_a: assert property (
    (r.st == ST_RDAT && r.cnt < BIT_ACK) |-> (sda_oe == !r.tx[7]))
    else $error("read bit not on sda");

  set_addr_a: assert property (
    (stop && r.st == ST_WDAT && !r.got)
      |=> (r.st == ST_IDLE && r.addr == $past(r.addr)))
    else $error("set address stop misbehaved");

  read_stop_a: assert property (
    (stop && r.st == ST_RDAT) |=> (r.st == ST_IDLE && r.addr == $past(r.addr)))
    else $error("read stop changed state");

  seq_next_a: assert property (
    (fall && r.st == ST_RDAT && r.cnt == BIT_ACK && r.mack && !start && !stop)
      |=> (r.st == ST_RDAT && r.cnt == '0))
    else $error("master ack did not fetch next byte");

  lead_skip_a: assert property (
    (start && !busy) |=> (r.st == ST_DEV && r.cnt == BIT_LEAD))
    else $error("start did not arm the bit counter");

  commit_end_a: assert property (
    (busy && r.tmr == TW'(WR_CYC - 1)) |=> (r.st == ST_IDLE))
    else $error("commit cycle did not end");

  idle_quiet_a: assert property (
    (r.st == ST_IDLE && !start) |=> !sda_oe)
    else $error("sda driven while idle");

  commit_c: cover property (stop && r.st == ST_WDAT && r.got);
  seq_read_c: cover property (ld && r.st == ST_RDAT);
  set_addr_c: cover property (stop && r.st == ST_WDAT && !r.got);
  poll_nack_c: cover property (busy && start);
  abort_c: cover property (stop && r.st == ST_WDAT && r.cnt != '0);

endmodule : seas_slave
`default_nettype wire

// *** sim/seas_master_model.sv ***
// Purpose: two-wire bus master model for the serial memory slave
// Assumes: scl idles high; sda pull-up is resolved in the bench
// Notes: one bit is 8 core clocks; scl low 5, high 3; sda moves mid low
`timescale 1ns/1ns
`default_nettype none
module seas_master_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_drv
);
  initial begin
    scl     = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  // also a repeated start; sda rises only after the slave's release time
  task automatic start();
    tick(3);
    sda_drv = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(3);
    sda_drv = 1'b0;
    tick(3);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    tick(3);
    sda_drv = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(3);
    sda_drv = 1'b1;
    tick(6);
  endtask : stop
  task automatic bitx(input logic b, output logic s);
    tick(3);
    sda_drv = b;
    tick(2);
    scl = 1'b1;
    tick(2);
    s = sda;
    tick(1);
    scl = 1'b0;
  endtask : bitx
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(d[i], s);
    bitx(1'b1, s);
    ack = ~s;
  endtask : wbyte
  // mack low keeps sda high in the ninth clock, ending the read
  task automatic rbyte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(~mack, s);
  endtask : rbyte
endmodule : seas_master_model
`default_nettype wire

// *** sim/seas_tb.sv ***
// Purpose: self-checking bench of the serial memory slave
// Assumes: commit time shortened to 200 cycles
// Notes: memory is only compared where the bench has written it
`timescale 1ns/1ns
`default_nettype none
module serial_eeprom_access_slave_tb_top;
  import seas_pkg::*;
  logic       core_clk;
  logic       nrst;
  wire logic  scl;
  wire logic  sda_m;
  wire logic  sda;
  logic       sda_out;
  logic       sda_oe;
  logic       busy;
  logic [7:0] rnd;
  logic [7:0] mem [logic [14:0]];
  int         failures;
  int         checked;
  // open drain: the slave can only pull low, the pull-up wins otherwise
  assign sda = sda_m & (sda_oe ? sda_out : 1'b1);
  seas_slave #(.WR_CYC(200)) u_seas_slave (.core_clk(core_clk), .nrst(nrst), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .busy(busy));
  seas_master_model m0 (.clk(core_clk), .sda(sda), .scl(scl), .sda_drv(sda_m));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  // writes roll inside a 128-byte page
  function automatic logic [14:0] roll(input logic [14:0] b, input int i);
    return {b[14:7], b[6:0] + 7'(i)};
  endfunction : roll
  task automatic conclude();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic sendb(input logic [7:0] d, input logic exp);
    logic a;
    m0.wbyte(d, a);
    chk(8'(a), 8'(exp), "ack");
  endtask : sendb
  task automatic seek(input logic [14:0] a, input logic exp);
    m0.start();
    sendb(8'hAE, exp);
    sendb({1'b0, a[14:8]}, exp);
    sendb(a[7:0], exp);
  endtask : seek
  task automatic wr(input logic [14:0] a, input int n);
    seek(a, 1'b1);
    for (int i = 0; i < n; i++) begin
      rnd = lfsr(rnd);
      if (i < FIFO_DEPTH) mem[roll(a, i)] = rnd;
      sendb(rnd, i < FIFO_DEPTH);
    end
    m0.stop();
    chk(8'(busy), 8'h01, "busy");
  endtask : wr
  task automatic rd(input logic [14:0] a, input int n);
    logic [7:0] d;
    m0.start();
    sendb(8'hAF, 1'b1);
    for (int i = 0; i < n; i++) begin
      m0.rbyte(i < n - 1, d);
      chk(d, mem[a + 15'(i)], "data");
    end
    m0.stop();
  endtask : rd
  task automatic waitidle();
    int k;
    for (k = 0; k < 400 && busy !== 1'b0; k++) @(negedge core_clk);
    if (k == 400) begin
      failures++;
      conclude();
    end
  endtask : waitidle
  initial begin
    logic [7:0] ids [5];
    logic       s;
    nrst = 1'b0;
    rnd = 8'h1A;
    repeat (10) @(negedge core_clk);
    nrst = 1'b1;
    repeat (6) @(negedge core_clk);
    // overfill the write buffer: byte 33 refused, 32 committed
    wr(15'h0000, 33);
    m0.start();
    sendb(8'hAE, 1'b0);
    m0.stop();
    waitidle();
    seek(15'h0000, 1'b1);
    rd(15'h0000, FIFO_DEPTH);
    wr(15'h7FFE, 2);
    waitidle();
    seek(15'h7FFE, 1'b1);
    rd(15'h7FFE, 4);
    wr(15'h007E, 2);
    waitidle();
    wr(15'h0080, 2);
    waitidle();
    seek(15'h007E, 1'b1);
    rd(15'h007E, 4);
    // stop inside the second data byte: the whole load is dropped
    seek(15'h0000, 1'b1);
    sendb(~mem[15'h0000], 1'b1);
    for (int i = 0; i < 4; i++) m0.bitx(~mem[15'h0000][7 - i], s);
    m0.stop();
    chk(8'(busy), 8'h00, "busy");
    seek(15'h0000, 1'b1);
    m0.stop();
    chk(8'(busy), 8'h00, "busy");
    rd(15'h0000, 1);
    rd(15'h0001, 1);
    rnd = lfsr(rnd);
    // write bit forced low so a random match never starts a read
    ids = '{8'hAE, 8'hDE, 8'hAC, 8'h5E, {rnd[7:1], 1'b0}};
    foreach (ids[i]) begin
      m0.start();
      sendb(ids[i], ids[i][7:1] == ARRAY_ID || ids[i][7:1] == CTRL_ID);
      m0.stop();
    end
    nrst = 1'b0;
    repeat (3) @(negedge core_clk);
    nrst = 1'b1;
    repeat (6) @(negedge core_clk);
    rd(15'h0000, 2);
    conclude();
  end
endmodule : serial_eeprom_access_slave_tb_top
`default_nettype wire
